// File: rhs_defs.svh
// constants for the pulse-controlled wiper stepper: positions and timing
// assumes the includer compiles it once per unit; guarded against repeats
`ifndef RHS_DEFS_SVH
`define RHS_DEFS_SVH

// clock rate of CLK_SYS
`define RHS_CLK_MHZ 100
`define RHS_CYC_PER_US (`RHS_CLK_MHZ)
`define RHS_CYC_PER_MS (`RHS_CLK_MHZ * 1000)

// position range and reset value
`define RHS_POS_W 6
`define RHS_POS_RST 6'h00
`define RHS_POS_MAX 6'h3F
`define RHS_NV_BIT 3

// times in their own units
`define RHS_T_SEP_MS 1
`define RHS_T_HOLD_MS 1000
`define RHS_T_REPEAT_MS 100
`define RHS_T_SAVE_MS 2000
`define RHS_T_PROC_US 1

// derived cycle counts
`define RHS_SEP_CYC (`RHS_T_SEP_MS * `RHS_CYC_PER_MS)
`define RHS_HOLD_CYC (`RHS_T_HOLD_MS * `RHS_CYC_PER_MS)
`define RHS_REPEAT_CYC (`RHS_T_REPEAT_MS * `RHS_CYC_PER_MS)
`define RHS_SAVE_CYC (`RHS_T_SAVE_MS * `RHS_CYC_PER_MS)
`define RHS_PROC_CYC (`RHS_T_PROC_US * `RHS_CYC_PER_US)

`endif

// File: rhs_pkg.sv
// types shared by the wiper stepper
// assumes rhs_defs.svh is reachable on the include path
`include "rhs_defs.svh"

package rhs_pkg;
  // control configuration chosen at power-up
  typedef enum logic {RHS_MODE_SINGLE, RHS_MODE_DUAL} rhs_mode_type;
  // one tap position, lowest tap is zero
  typedef logic [`RHS_POS_W-1:0] rhs_pos_type;
endpackage

// File: rhs_pulse_src.sv
// pushbutton and processor pulse source facing the wiper stepper
// assumes the bench clock; lines change only at its falling edge
`timescale 1ns/1ps

module rhs_pulse_src (
  input wire logic clk, // bench clock
  output logic up_n, // up contact line
  output logic dn_n, // down contact line
  output logic pr_n // processor pulse line
);
  // idle lines sit high through the pull-ups
  initial begin
    up_n = 1'b1;
    dn_n = 1'b1;
    pr_n = 1'b1;
  end

  // sel: bit 0 up, bit 1 down, bit 2 processor
  task automatic put(input logic [2:0] sel, input logic v);
    if (sel[0]) up_n = v;
    if (sel[1]) dn_n = v;
    if (sel[2]) pr_n = v;
  endtask

  // chatter first, then a steady low of len cycles, then release
  task automatic press(input logic [2:0] sel, input int len, input int bnc);
    for (int i = 0; i < bnc + len; i++) begin
      @(negedge clk);
      put(sel, (i < bnc) ? i[0] : 1'b0);
    end
    @(negedge clk);
    put(sel, 1'b1);
  endtask
endmodule

// File: rhs_wiper_ctrl.sv
// wiper stepper: pulse filtering, auto-repeat, direction and save logic
// assumes inputs synchronous to CLK_SYS and a nonvolatile store outside
`timescale 1ns/1ps
`include "rhs_defs.svh"

// Overview of operation
// - wiper is a 6-bit tap, 64 positions
// - mode latched from strap after power-up
// - all three control inputs active low
// - falling edge starts a pulse
// - one recognised pulse moves one tap
// - gaps under 1 ms merge contact pulses, under 1 us processor pulses
// - after 1 s hold, step every 100 ms
// - single mode uses up contact, ignores down
// - first move opposes previous movement direction
// - reverse after 1 s idle or at end
// - processor input steps like single button in both modes, unless a dual contact step comes in the same cycle
// - processor input accepts narrower pulses
// - floating down contact selects dual mode
// - dual: up raises, down lowers, immediately
// - dual: saturate at ends, no reversal
// - contact inputs debounced internally
// - restore saved position at power-up
// - save new position after 2 s settling
// - save first change, then bit-3 changes
module rhs_wiper_ctrl #(
  parameter logic [31:0] SEP_CYC = `RHS_SEP_CYC,
  parameter logic [31:0] HOLD_CYC = `RHS_HOLD_CYC,
  parameter logic [31:0] REPEAT_CYC = `RHS_REPEAT_CYC,
  parameter logic [31:0] SAVE_CYC = `RHS_SAVE_CYC,
  parameter logic [31:0] PROC_CYC = `RHS_PROC_CYC
) (
  input wire logic CLK_SYS, // system clock
  input wire logic RST_N, // power-up reset, async
  input wire logic UP_CONTACT_IN_N, // up contact, low = closed
  input wire logic DOWN_CONTACT_IN_N, // down contact, low = closed
  input wire logic PROC_PULSE_IN_N, // processor pulse, low = active
  input wire logic DOWN_TIED_SUPPLY, // high when down contact is strapped
  input wire rhs_pkg::rhs_pos_type NV_POS_IN, // saved position from store
  output rhs_pkg::rhs_pos_type WIPER_POS, // current tap
  output rhs_pkg::rhs_mode_type CTRL_MODE, // latched configuration
  output logic NV_WR_STB, // one-cycle save request
  output rhs_pkg::rhs_pos_type NV_WR_DATA // position to save
);
  import rhs_pkg::*;

  localparam int NCH = 3; // 0 up contact, 1 down contact, 2 processor

  logic [NCH-1:0] raw_act;
  logic [NCH-1:0] lvl_w;
  logic [NCH-1:0] step_w;

  // inputs are active low
  assign raw_act = {~PROC_PULSE_IN_N, ~DOWN_CONTACT_IN_N, ~UP_CONTACT_IN_N};

  // per input: level filter, then press and auto-repeat step pulses
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      // processor input gets the short window so it can step faster
      localparam logic [31:0] THR = (g == 2) ? PROC_CYC : SEP_CYC;
      logic [31:0] flt_cnt_r;
      logic [31:0] flt_cnt_nxt;
      logic lvl_r;
      logic lvl_nxt;
      logic lvl_d_r;
      logic [31:0] hold_r;
      logic [31:0] hold_nxt;
      logic step_r;
      logic step_nxt;

      // a level must persist THR cycles; bounce and short gaps vanish
      always_comb begin
        flt_cnt_nxt = 32'h0;
        lvl_nxt = lvl_r;
        if (raw_act[g] != lvl_r) begin
          if (flt_cnt_r >= THR - 32'h1) begin
            lvl_nxt = raw_act[g];
          end else begin
            flt_cnt_nxt = flt_cnt_r + 32'h1;
          end
        end
      end

      // step on press, then after the long hold at the repeat rate
      always_comb begin
        hold_nxt = 32'h0;
        step_nxt = 1'b0;
        if (lvl_r && !lvl_d_r) begin
          step_nxt = 1'b1;
        end else if (lvl_r) begin
          if (hold_r >= HOLD_CYC - 32'h1) begin
            step_nxt = 1'b1;
            hold_nxt = HOLD_CYC - REPEAT_CYC;
          end else begin
            hold_nxt = hold_r + 32'h1;
          end
        end
      end

      always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          flt_cnt_r <= 32'h0;
          lvl_r <= 1'b0;
          lvl_d_r <= 1'b0;
          hold_r <= 32'h0;
          step_r <= 1'b0;
        end else begin
          flt_cnt_r <= flt_cnt_nxt;
          lvl_r <= lvl_nxt;
          lvl_d_r <= lvl_r;
          hold_r <= hold_nxt;
          step_r <= step_nxt;
        end
      end

      assign lvl_w[g] = lvl_r;
      assign step_w[g] = step_r;
    end
  endgenerate

  // mode strap caught on the first edge after reset release
  logic started_r;
  logic started_nxt;
  rhs_mode_type mode_r;
  rhs_mode_type mode_nxt;

  always_comb begin
    started_nxt = 1'b1;
    mode_nxt = mode_r;
    if (!started_r) begin
      mode_nxt = DOWN_TIED_SUPPLY ? RHS_MODE_SINGLE : RHS_MODE_DUAL;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      started_r <= 1'b0;
      mode_r <= RHS_MODE_DUAL;
    end else begin
      started_r <= started_nxt;
      mode_r <= mode_nxt;
    end
  end

  // position and single-button direction state
  rhs_pos_type pos_r;
  rhs_pos_type pos_nxt;
  logic dir_up_r;
  logic dir_up_nxt;
  logic pend_rev_r;
  logic pend_rev_nxt;
  logic [31:0] idle_r;
  logic [31:0] idle_nxt;
  logic dual_c;
  logic up_req;
  logic dn_req;
  logic sgl_req;
  logic sgl_act;
  logic eff_up;

  assign dual_c = (mode_r == RHS_MODE_DUAL);
  // in dual mode a held opposite contact blocks the other
  assign up_req = dual_c && step_w[0] && !lvl_w[1];
  assign dn_req = dual_c && step_w[1] && !lvl_w[0];
  // down contact has no path in single mode
  assign sgl_req = (!dual_c && step_w[0]) || step_w[2];
  assign sgl_act = (!dual_c && lvl_w[0]) || lvl_w[2];

  // contact requests win a same-cycle clash with the processor input
  always_comb begin
    eff_up = dir_up_r;
    pos_nxt = pos_r;
    dir_up_nxt = dir_up_r;
    pend_rev_nxt = pend_rev_r;
    idle_nxt = 32'h0;
    if (!sgl_act) begin
      if (idle_r >= HOLD_CYC) begin
        pend_rev_nxt = 1'b1;
        idle_nxt = idle_r;
      end else begin
        idle_nxt = idle_r + 32'h1;
      end
    end
    if (!started_r) begin
      pos_nxt = NV_POS_IN;
    end else if (up_req || dn_req) begin
      if (up_req && pos_r != `RHS_POS_MAX) begin
        pos_nxt = pos_r + 6'h01;
      end else if (dn_req && pos_r != `RHS_POS_RST) begin
        pos_nxt = pos_r - 6'h01;
      end
    end else if (sgl_req) begin
      eff_up = pend_rev_r ? !dir_up_r : dir_up_r;
      if (eff_up && pos_r == `RHS_POS_MAX) begin
        eff_up = 1'b0;
      end else if (!eff_up && pos_r == `RHS_POS_RST) begin
        eff_up = 1'b1;
      end
      pos_nxt = eff_up ? pos_r + 6'h01 : pos_r - 6'h01;
      dir_up_nxt = eff_up;
      pend_rev_nxt = 1'b0;
    end
  end

  // no history at power-up: pending reversal of "down" gives an up move
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pos_r <= `RHS_POS_RST;
      dir_up_r <= 1'b0;
      pend_rev_r <= 1'b1;
      idle_r <= 32'h0;
    end else begin
      pos_r <= pos_nxt;
      dir_up_r <= dir_up_nxt;
      pend_rev_r <= pend_rev_nxt;
      idle_r <= idle_nxt;
    end
  end

  // save scheduling: every change restarts the settling timer
  logic first_done_r;
  logic first_done_nxt;
  logic saved_b3_r;
  logic saved_b3_nxt;
  logic nv_pend_r;
  logic nv_pend_nxt;
  logic [31:0] nv_cnt_r;
  logic [31:0] nv_cnt_nxt;
  logic stb_r;
  logic stb_nxt;
  rhs_pos_type nv_data_r;
  rhs_pos_type nv_data_nxt;

  // bit-3 filter trades resolution of the stored copy for write endurance
  always_comb begin
    first_done_nxt = first_done_r;
    saved_b3_nxt = saved_b3_r;
    nv_pend_nxt = nv_pend_r;
    nv_cnt_nxt = nv_cnt_r;
    stb_nxt = 1'b0;
    nv_data_nxt = nv_data_r;
    if (!started_r) begin
      saved_b3_nxt = NV_POS_IN[`RHS_NV_BIT];
    end else if (pos_nxt != pos_r) begin
      nv_pend_nxt = 1'b1;
      nv_cnt_nxt = 32'h0;
    end else if (nv_pend_r) begin
      if (nv_cnt_r >= SAVE_CYC - 32'h1) begin
        nv_pend_nxt = 1'b0;
        nv_cnt_nxt = 32'h0;
        if (!first_done_r || pos_r[`RHS_NV_BIT] != saved_b3_r) begin
          stb_nxt = 1'b1;
          nv_data_nxt = pos_r;
          first_done_nxt = 1'b1;
          saved_b3_nxt = pos_r[`RHS_NV_BIT];
        end
      end else begin
        nv_cnt_nxt = nv_cnt_r + 32'h1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      first_done_r <= 1'b0;
      saved_b3_r <= 1'b0;
      nv_pend_r <= 1'b0;
      nv_cnt_r <= 32'h0;
      stb_r <= 1'b0;
      nv_data_r <= `RHS_POS_RST;
    end else begin
      first_done_r <= first_done_nxt;
      saved_b3_r <= saved_b3_nxt;
      nv_pend_r <= nv_pend_nxt;
      nv_cnt_r <= nv_cnt_nxt;
      stb_r <= stb_nxt;
      nv_data_r <= nv_data_nxt;
    end
  end

  // outputs straight from flip-flops
  assign WIPER_POS = pos_r;
  assign CTRL_MODE = mode_r;
  assign NV_WR_STB = stb_r;
  assign NV_WR_DATA = nv_data_r;

  // checks on the stepping and saving behaviour
  default clocking cb_chk @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence s_up_press;
    !lvl_w[0] ##1 lvl_w[0];
  endsequence

  a_press_step: assert property (s_up_press |=> step_w[0])
    else $error("press did not give a step");
  a_filter_cause: assert property ($rose(lvl_w[0]) |-> $past(raw_act[0]))
    else $error("filtered level rose without input");
  a_one_tap: assert property (started_r |=> (WIPER_POS - $past(WIPER_POS)) inside {6'h00, 6'h01, 6'h3F})
    else $error("wiper moved more than one tap");
  a_mode_fixed: assert property (started_r |=> $stable(CTRL_MODE))
    else $error("mode changed after power-up");
  a_restore_pos: assert property ($rose(started_r) |-> WIPER_POS == $past(NV_POS_IN))
    else $error("saved position not restored");
  a_dual_up: assert property (started_r && up_req && pos_r != 6'h3F |=> WIPER_POS == $past(WIPER_POS) + 6'h01)
    else $error("dual up step missing");
  a_dual_sat: assert property (started_r && up_req && pos_r == 6'h3F |=> WIPER_POS == 6'h3F)
    else $error("dual mode left top end");
  a_single_ignore: assert property (started_r && !dual_c && !sgl_req |=> $stable(WIPER_POS))
    else $error("single mode moved without up or processor step");
  a_both_hold: assert property (started_r && dual_c && lvl_w[0] && lvl_w[1] && !step_w[2]
                                |=> $stable(WIPER_POS))
    else $error("both contacts held but wiper moved");
  a_end_reverse: assert property (started_r && sgl_req && !up_req && !dn_req && pos_r == 6'h3F
                                  |=> WIPER_POS == 6'h3E)
    else $error("no reversal at top end");
  a_save_data: assert property (NV_WR_STB |-> NV_WR_DATA == $past(WIPER_POS) ##1 !NV_WR_STB)
    else $error("save strobe or data wrong");
endmodule

// File: testbench.sv
// self-checking bench for the wiper stepper, short timing parameters
// assumes rhs_pkg and rhs_pulse_src are compiled first
`timescale 1ns/1ps

module testbench;
  import rhs_pkg::*;
  logic CLK_SYS, RST_N, DOWN_TIED_SUPPLY, up_n, dn_n, pr_n, NV_WR_STB, watch;
  rhs_pos_type NV_POS_IN, WIPER_POS, NV_WR_DATA, last_pos;
  rhs_mode_type CTRL_MODE;
  logic [6:0] q[$];
  logic [31:0] rnd;
  int mismatches = 0;
  int tests_run = 0;
  int p;

  rhs_pulse_src m (.clk(CLK_SYS), .up_n(up_n), .dn_n(dn_n), .pr_n(pr_n));
  rhs_wiper_ctrl #(.SEP_CYC(4), .HOLD_CYC(40), .REPEAT_CYC(8), .SAVE_CYC(120), .PROC_CYC(2)) dut (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .UP_CONTACT_IN_N(up_n), .DOWN_CONTACT_IN_N(dn_n),
    .PROC_PULSE_IN_N(pr_n), .DOWN_TIED_SUPPLY(DOWN_TIED_SUPPLY), .NV_POS_IN(NV_POS_IN),
    .WIPER_POS(WIPER_POS), .CTRL_MODE(CTRL_MODE), .NV_WR_STB(NV_WR_STB), .NV_WR_DATA(NV_WR_DATA));

  always #5 CLK_SYS = ~CLK_SYS;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic check(input string nm, input logic [6:0] e, input logic [6:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // notes: bit 6 clear for a tap change, set for a save
  task automatic note(input int v);
    q.push_back(7'(v));
  endtask

  // bounded wait for every noted result to show up
  task automatic drain();
    int n;
    n = 0;
    while (q.size() > 0 && n < 700) begin
      @(negedge CLK_SYS);
      n++;
    end
    if (q.size() > 0) begin
      mismatches++;
      close_out();
    end
  endtask

  // press, wait for results, then leave a gap longer than the merge window
  task automatic go(input logic [2:0] sel, input int len, input int bnc);
    m.press(sel, len, bnc);
    drain();
    repeat (10) @(negedge CLK_SYS);
  endtask

  // power-up with a strap and a stored tap
  task automatic rst(input logic single, input int nv);
    watch = 1'b0;
    RST_N = 1'b0;
    DOWN_TIED_SUPPLY = single;
    NV_POS_IN = 6'(nv);
    repeat (20) @(negedge CLK_SYS);
    RST_N = 1'b1;
    @(negedge CLK_SYS);
    check("restored tap", 7'(nv), {1'b0, WIPER_POS});
    check("mode", {6'h00, !single}, {6'h00, CTRL_MODE});
    last_pos = WIPER_POS;
    watch = 1'b1;
  endtask

  // every tap change or save strobe takes the oldest note
  always @(negedge CLK_SYS) begin
    if (watch && WIPER_POS !== last_pos) begin
      check("tap", (q.size() > 0) ? q.pop_front() : 7'hXX, {1'b0, WIPER_POS});
      last_pos = WIPER_POS;
    end
    if (watch && NV_WR_STB !== 1'b0) begin
      check("save", (q.size() > 0) ? q.pop_front() : 7'hXX, {1'b1, NV_WR_DATA});
    end
  end

  initial begin
    CLK_SYS = 1'b0;
    watch = 1'b0;
    rnd = xs(32'h00000028);
    p = int'(rnd[4:0]);
    rst(1'b0, p);
    note(p + 1); go(3'b001, 8, int'(rnd[2:0]));
    note(p); go(3'b010, 8, 0);
    go(3'b001, 2, 0);
    // merged pair, then a full gap so the next press starts clean
    note(p + 1); m.press(3'b001, 6, 0); go(3'b001, 6, 0);
    go(3'b011, 20, 0);
    for (int i = 2; i < 6; i++) note(p + i);
    go(3'b001, 60, 0);
    for (int i = p + 6; i < 64; i++) note(i);
    // the save falls due while the button is still held at the top
    note(64 + 63); go(3'b001, 600, 0);
    note(62); go(3'b010, 8, 0);
    repeat (130) @(negedge CLK_SYS);
    for (int i = 61; i >= 55; i--) note(i);
    go(3'b010, 84, 0);
    note(64 + 55); drain();
    note(56); go(3'b100, 3, 0);
    note(64 + 56); drain();
    rst(1'b1, 62);
    note(63); go(3'b001, 8, 0);
    note(62); go(3'b001, 8, 0);
    note(61); go(3'b001, 8, 0);
    go(3'b010, 8, 0);
    repeat (45) @(negedge CLK_SYS);
    note(62); go(3'b001, 8, 0);
    note(63); go(3'b100, 3, 0);
    note(62); go(3'b100, 3, 0);
    note(64 + 62); drain();
    close_out();
  end
endmodule
